// ==== rtl/tag_parity_pkg.sv ====
// Package of constants, register offsets and carrier types for the tag parity error handler
package tag_parity_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int ADDR_W = 34;   // Physical address width
  localparam int TAG_W  = 20;   // Tag probe result width

  // ----------------------------------------------------------------
  // Register byte offsets on APB
  // ----------------------------------------------------------------
  localparam logic [11:0] OFF_CTRL   = 12'h000;  // cache_controller_control
  localparam logic [11:0] OFF_UE     = 12'h004;  // uncorrectable_error_log
  localparam logic [11:0] OFF_UEA_LO = 12'h008;  // uncorrectable_error_address_log low
  localparam logic [11:0] OFF_UEA_HI = 12'h00C;  // uncorrectable_error_address_log high
  localparam logic [11:0] OFF_STAT   = 12'h010;  // bus_interface_status
  localparam logic [11:0] OFF_FA_LO  = 12'h014;  // bus_interface_fault_address low
  localparam logic [11:0] OFF_FA_HI  = 12'h018;  // bus_interface_fault_address high
  localparam logic [11:0] OFF_TAG    = 12'h01C;  // tag_probe_result_reg

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CTRL_ALLOC_BIT  = 0;  // allocation_enable_bit
  localparam int UE_PARITY_BIT   = 0;  // parity_fault_bit
  localparam int UE_MISSED_BIT   = 1;  // Missed error flag
  localparam int STAT_TPERR_BIT  = 0;  // tag_parity_flag
  localparam int STAT_TCPERR_BIT = 1;  // tag_control_parity_flag

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic CTRL_ALLOC_RST = 1'b1;  // Allocation enabled out of reset

  // ----------------------------------------------------------------
  // Carrier types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic              valid;     // Probe read the tag stores this cycle
    logic              from_cpu;  // 1: processor cycle, 0: system-bus snoop
    logic              rd_xchg;   // Bus read or exchange (snoop) / read block (cpu)
    logic              tag_perr;  // Tag parity mismatch
    logic              tc_perr;   // Tag-control parity mismatch
    logic [ADDR_W-1:0] addr;      // Physical address of the probe
    logic [TAG_W-1:0]  tag;       // Tag value returned by the probe
  } probe_s;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } apb_req_s;

endpackage : tag_parity_pkg

// ==== rtl/cache_tag_parity_error_handler.sv ====
// Tag and tag-control parity error handler for the board-level second-level cache
//
// Notes on behaviour
// - Check parity only on a probe
// - Processor probes every cacheable load or store
// - Processor probe error forces cache miss
// - Capture tag probe result on processor error
// - Processor probe error raises machine check
// - Set tag or tag-control status flags
// - Fault address holds failing probe address
// - Bus probe error reports fail outcome
// - Log bus error, address; raise error line
// - Flag uncorrectable data on bus read/exchange with a tag parity error
// - No data moved, no cache change
// - Allocation off until cleared and re-enabled
// - Processor probe error gives null transaction
// - No bus data, cache state unchanged
// - Fatal_cycle_ack ack and system error line
// - Log, freeze, disable allocation for processor
// - Set parity bit, latch bus address
// - Further errors only mark missed error
// - Uncorrectable data error forces machine check
// - Correctable errors use hardware error interrupt
// - System error line gives hardware interrupt
`timescale 1ns/1ps

module cache_tag_parity_error_handler
(
  input  wire logic                             clk,
  input  wire logic                             rst_n,
  // APB slave
  input  wire logic                             psel,
  input  wire logic                             penable,
  input  wire logic                             pwrite,
  input  wire logic [11:0]                      paddr,
  input  wire logic [31:0]                      pwdata,
  output logic      [31:0]                      prdata,
  output logic                                  pready,
  output logic                                  pslverr,
  // Probe from tag store compare logic (same clock)
  input  wire tag_parity_pkg::probe_s           probe,
  input  wire logic                             cacheable,
  // Data-path uncorrectable and correctable events
  input  wire logic                             data_uncorrectable,
  input  wire logic                             data_correctable,
  input  wire logic                             latent_error,
  // System-bus timing pins (from outside the clock domain)
  input  wire logic                             bus_phase_zero_pin,
  input  wire logic                             bus_idle_pin,
  input  wire logic                             bus_read_data_pin,
  input  wire logic                             sys_err_in_pin,
  // Outputs
  output logic                                  probe_req,
  output logic                                  force_miss,
  output logic                                  probe_fail,
  output logic                                  block_data,
  output logic                                  null_transaction,
  output logic                                  fatal_cycle_ack,
  output logic                                  machine_check,
  output logic                                  hw_error_irq,
  output logic                                  sys_err_out,
  output logic                                  data_uncorrectable_flag_line,
  output logic                                  alloc_enable
);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [3:0] sync_a;  // First stage, read only by second stage
  logic [3:0] sync_b;  // Second stage, safe to use

  // Two flops on every pin that comes from the bus timing domain
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      sync_a <= 4'h0;
      sync_b <= 4'h0;
    end
    else
    begin
      sync_a <= {sys_err_in_pin, bus_read_data_pin, bus_idle_pin, bus_phase_zero_pin};
      sync_b <= sync_a;
    end
  end

  wire bus_t0       = sync_b[0];  // Synchronised phase-zero
  wire bus_idle     = sync_b[1];  // Synchronised idle cycle
  wire bus_rd_data  = sync_b[2];  // Memory returning read data
  wire sys_err_seen = sync_b[3];  // Any node driving system error
  // Raw pins and the first stage are never read past this point

  // ----------------------------------------------------------------
  // Probe decode
  // ----------------------------------------------------------------
  // Parity is qualified by probe valid so no error exists without a read
  wire perr       = probe.valid & (probe.tag_perr | probe.tc_perr);
  wire cpu_err    = perr & probe.from_cpu;
  wire bus_err    = perr & ~probe.from_cpu;
  wire bus_rd_err = bus_err & probe.rd_xchg & probe.tag_perr;

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic                              alloc_bit;      // cache_controller_control
  logic                              parity_fault;   // parity_fault_bit
  logic                              missed;         // Missed error bit
  logic [tag_parity_pkg::ADDR_W-1:0] ue_addr;        // uncorrectable_error_address_log
  logic                              tperr;          // tag_parity_flag
  logic                              tcperr;         // tag_control_parity_flag
  logic [tag_parity_pkg::ADDR_W-1:0] fault_addr;     // bus_interface_fault_address
  logic [tag_parity_pkg::TAG_W-1:0]  tag_result;     // tag_probe_result_reg
  logic                              err_pending;    // System error waits for t0 or idle
  logic                              dflag_pending;  // Flag waits for read data phase

  // Register decodes; pready is constant, so the access phase is the write edge
  wire frozen   = parity_fault | missed;              // Log holds its first error
  wire wr_acc   = psel & penable & pwrite;
  wire ue_wr    = wr_acc & (paddr == tag_parity_pkg::OFF_UE);
  wire ctrl_wr  = wr_acc & (paddr == tag_parity_pkg::OFF_CTRL);
  wire stat_wr  = wr_acc & (paddr == tag_parity_pkg::OFF_STAT);
  // Phase zero and idle both give a slot for the error line
  wire drive_err = err_pending & (bus_t0 | bus_idle);

  // Control register: any probe error clears the enable bit; only a write sets it again
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      alloc_bit <= tag_parity_pkg::CTRL_ALLOC_RST;
    else if (perr)
      alloc_bit <= 1'b0;
    else if (ctrl_wr)
      alloc_bit <= pwdata[tag_parity_pkg::CTRL_ALLOC_BIT];
  end

  // Allocation needs both the enable bit and a clean log
  assign alloc_enable = alloc_bit & ~frozen;

  // Uncorrectable log: first error in full, later ones as missed
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      parity_fault <= 1'b0;
      missed       <= 1'b0;
      ue_addr      <= '0;
    end
    else if (perr && !frozen)
    begin
      parity_fault <= 1'b1;
      ue_addr      <= probe.addr;
    end
    else if (perr)
      missed <= 1'b1;
    else if (ue_wr)
    begin
      // Write one to clear; clearing both bits unfreezes the log
      if (pwdata[tag_parity_pkg::UE_PARITY_BIT])
        parity_fault <= 1'b0;
      if (pwdata[tag_parity_pkg::UE_MISSED_BIT])
        missed <= 1'b0;
    end
  end

  // Processor-side status, fault address and tag result
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      tperr      <= 1'b0;
      tcperr     <= 1'b0;
      fault_addr <= '0;
      tag_result <= '0;
    end
    else if (cpu_err)
    begin
      tperr      <= tperr | probe.tag_perr;
      tcperr     <= tcperr | probe.tc_perr;
      fault_addr <= probe.addr;
      tag_result <= probe.tag;
    end
    else if (stat_wr)
    begin
      if (pwdata[tag_parity_pkg::STAT_TPERR_BIT])
        tperr <= 1'b0;
      if (pwdata[tag_parity_pkg::STAT_TCPERR_BIT])
        tcperr <= 1'b0;
    end
  end

  // System error waits for the next phase-zero or idle bus cycle
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      err_pending <= 1'b0;
    else if (perr)
      err_pending <= 1'b1;
    else if (drive_err)
      err_pending <= 1'b0;
  end

  // Limitation: the flag stands for the first synced read-data cycle only
  // Data flag waits for memory to return the read data
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      dflag_pending <= 1'b0;
    else if (bus_rd_err)
      dflag_pending <= 1'b1;
    else if (bus_rd_data)
      dflag_pending <= 1'b0;
  end

  // Registered outputs
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      sys_err_out                  <= 1'b0;
      data_uncorrectable_flag_line <= 1'b0;
      machine_check                <= 1'b0;
      hw_error_irq                 <= 1'b0;
    end
    else
    begin
      sys_err_out                  <= drive_err;
      data_uncorrectable_flag_line <= dflag_pending & bus_rd_data;
      machine_check                <= cpu_err | data_uncorrectable;
      hw_error_irq                 <= data_correctable | latent_error
                                      | sys_err_seen;
    end
  end

  // ----------------------------------------------------------------
  // Probe responses, same cycle so the cycle can be steered
  // ----------------------------------------------------------------
  // Combinational so the cycle is steered before it reaches the bus
  assign probe_req        = probe.from_cpu & cacheable;
  assign force_miss       = cpu_err;
  assign probe_fail       = bus_err;
  assign block_data       = perr;
  assign null_transaction = cpu_err;
  assign fatal_cycle_ack  = cpu_err;

  // ----------------------------------------------------------------
  // APB read mux, zero wait state
  // ----------------------------------------------------------------
  // Unmapped or unaligned offsets read as zero
  wire [31:0] rd_mux =
      (paddr == tag_parity_pkg::OFF_CTRL)   ? {31'h0, alloc_bit} :
      (paddr == tag_parity_pkg::OFF_UE)     ? {30'h0, missed, parity_fault} :
      (paddr == tag_parity_pkg::OFF_UEA_LO) ? ue_addr[31:0] :
      (paddr == tag_parity_pkg::OFF_UEA_HI) ? {30'h0, ue_addr[33:32]} :
      (paddr == tag_parity_pkg::OFF_STAT)   ? {30'h0, tcperr, tperr} :
      (paddr == tag_parity_pkg::OFF_FA_LO)  ? fault_addr[31:0] :
      (paddr == tag_parity_pkg::OFF_FA_HI)  ? {30'h0, fault_addr[33:32]} :
      (paddr == tag_parity_pkg::OFF_TAG)    ? {12'h0, tag_result} : 32'h0;
  // Eight aligned words from offset zero
  wire mapped = (paddr[11:5] == 7'h00) & (paddr[1:0] == 2'h0);

  // Trade-off: no wait states, so reads show register contents directly
  assign pready  = 1'b1;                 // Always zero wait states
  assign pslverr = psel & penable & ~mapped;
  assign prdata  = rd_mux;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  // A frozen log keeps its address and only marks a missed error
  property p_log_freeze;
    @(posedge clk) disable iff (!rst_n)
    (perr && frozen) |=> (ue_addr == $past(ue_addr)) && missed;
  endproperty
  a_log_freeze: assert property (p_log_freeze) else $error("frozen log changed");

  // Any probe error turns allocation off from the next cycle
  property p_alloc_off;
    @(posedge clk) disable iff (!rst_n)
    perr |=> !alloc_enable;
  endproperty
  a_alloc_off: assert property (p_alloc_off) else $error("allocation not disabled");

  // The first error is captured in full
  property p_first_log;
    @(posedge clk) disable iff (!rst_n)
    (perr && !frozen) |=> parity_fault && (ue_addr == $past(probe.addr));
  endproperty
  a_first_log: assert property (p_first_log) else $error("error not logged");

  // Processor error: fatal_cycle_ack ack and null cycle now, machine check next
  property p_cpu_mc;
    @(posedge clk) disable iff (!rst_n)
    cpu_err |-> fatal_cycle_ack && null_transaction ##1 machine_check;
  endproperty
  a_cpu_mc: assert property (p_cpu_mc) else $error("no machine check");

  // Processor registers capture the failing probe
  property p_fault_addr;
    @(posedge clk) disable iff (!rst_n)
    cpu_err |=> fault_addr == $past(probe.addr) && tag_result == $past(probe.tag);
  endproperty
  a_fault_addr: assert property (p_fault_addr) else $error("fault address wrong");

  // Snooped error fails the probe without steering the processor
  property p_bus_fail;
    @(posedge clk) disable iff (!rst_n)
    bus_err |-> probe_fail && block_data && !force_miss;
  endproperty
  a_bus_fail: assert property (p_bus_fail) else $error("fail outcome missing");

  // Error line pulses in the slot; pending clears unless a new error came
  property p_sys_err;
    @(posedge clk) disable iff (!rst_n)
    drive_err |=> sys_err_out && (!err_pending || $past(perr));
  endproperty
  a_sys_err: assert property (p_sys_err) else $error("system error not driven");

  // No probe, no error response
  property p_no_err_without_probe;
    @(posedge clk) disable iff (!rst_n)
    !probe.valid |-> !force_miss && !probe_fail;
  endproperty
  a_no_err_without_probe: assert property (p_no_err_without_probe) else $error("spurious error");

  // Status flags follow the parity bits of the failing processor probe
  property p_cpu_status;
    @(posedge clk) disable iff (!rst_n)
    cpu_err |=> (tperr || !$past(probe.tag_perr)) && (tcperr || !$past(probe.tc_perr));
  endproperty
  a_cpu_status: assert property (p_cpu_status) else $error("status flag not set");

  // Every probe error leaves the error line pending
  property p_err_pend;
    @(posedge clk) disable iff (!rst_n)
    perr |=> err_pending;
  endproperty
  a_err_pend: assert property (p_err_pend) else $error("error line not pending");

  // Snooped probes never steer the processor cycle
  property p_miss_only_cpu;
    @(posedge clk) disable iff (!rst_n)
    !probe.from_cpu |-> !force_miss && !null_transaction && !fatal_cycle_ack;
  endproperty
  a_miss_only_cpu: assert property (p_miss_only_cpu) else $error("snoop steered cpu");

  // Machine check only from a processor probe or uncorrectable data
  property p_mc_cause;
    @(posedge clk) disable iff (!rst_n)
    !(cpu_err || data_uncorrectable) |=> !machine_check;
  endproperty
  a_mc_cause: assert property (p_mc_cause) else $error("machine check without cause");

  // Clearing both log bits with no new error unfreezes the log
  property p_unfreeze;
    @(posedge clk) disable iff (!rst_n)
    (ue_wr && !perr && pwdata[tag_parity_pkg::UE_PARITY_BIT]
     && pwdata[tag_parity_pkg::UE_MISSED_BIT]) |=> !frozen;
  endproperty
  a_unfreeze: assert property (p_unfreeze) else $error("log still frozen");

  // Allocation stays off while any log bit is set
  property p_alloc_gate;
    @(posedge clk) disable iff (!rst_n)
    frozen |-> !alloc_enable;
  endproperty
  a_alloc_gate: assert property (p_alloc_gate) else $error("allocation while frozen");

  // Pending read error flags the returning data
  property p_dflag;
    @(posedge clk) disable iff (!rst_n)
    (dflag_pending && bus_rd_data) |=> data_uncorrectable_flag_line;
  endproperty
  a_dflag: assert property (p_dflag) else $error("data flag missing");

endmodule : cache_tag_parity_error_handler

// ==== bench/bus_node_model.sv ====
// Model of the system-bus timing pins that the handler watches
`timescale 1ns/1ps

module bus_node_model
(
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic [3:0] req,
  output logic            bus_phase_zero_pin,
  output logic            bus_idle_pin,
  output logic            bus_read_data_pin,
  output logic            sys_err_in_pin
);
  // ----------------------------------------------------------------
  // Pin stretchers
  // ----------------------------------------------------------------
  logic [1:0] cnt [4];  // Cycles left high per pin

  // Three cycles high, long enough for the two-flop sync
  always_ff @(posedge clk)
  begin
    for (int i = 0; i < 4; i++)
    begin
      if (!rst_n)
        cnt[i] <= 2'h0;
      else if (req[i])
        cnt[i] <= 2'h3;
      else if (cnt[i] != 2'h0)
        cnt[i] <= cnt[i] - 2'h1;
    end
  end

  // Lines sit low between events, as a released bus line
  assign bus_phase_zero_pin = (cnt[0] != 2'h0);
  assign bus_idle_pin       = (cnt[1] != 2'h0);
  assign bus_read_data_pin  = (cnt[2] != 2'h0);
  assign sys_err_in_pin     = (cnt[3] != 2'h0);
endmodule : bus_node_model

// ==== bench/tb.sv ====
// Self-checking testbench for the tag parity error handler
`timescale 1ns/1ps

module tb;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic                   clk, rst_n, psel, penable, pwrite, pready, pslverr;
  logic [11:0]            paddr;
  logic [31:0]            pwdata, prdata, rd;
  tag_parity_pkg::probe_s pr;         // Probe stimulus
  logic                   cacheable, err;
  logic [2:0]             ev;         // Uncorrectable, correctable, latent
  logic [3:0]             req;        // Pin events to the bus model
  logic                   t0p, idp, rdp, erp;
  logic                   probe_req, force_miss, probe_fail, block_data, null_tr, fack;
  logic                   mchk, irq, sys_err_out, ucflag, alloc;
  int                     n_fail, n_compared, cyc;
  wire  [3:0]             wv = {irq, ucflag, sys_err_out, mchk};  // Watched pulses
  localparam logic [33:0] A_CPU = 34'h2ABCD1234;
  localparam logic [33:0] A_BUS = 34'h155667788;

  // ----------------------------------------------------------------
  // Design and bus model
  // ----------------------------------------------------------------
  cache_tag_parity_error_handler i_dut
  (
    .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .probe(pr), .cacheable(cacheable), .data_uncorrectable(ev[0]),
    .data_correctable(ev[1]), .latent_error(ev[2]), .bus_phase_zero_pin(t0p),
    .bus_idle_pin(idp), .bus_read_data_pin(rdp), .sys_err_in_pin(erp),
    .probe_req(probe_req), .force_miss(force_miss), .probe_fail(probe_fail),
    .block_data(block_data), .null_transaction(null_tr), .fatal_cycle_ack(fack),
    .machine_check(mchk), .hw_error_irq(irq), .sys_err_out(sys_err_out),
    .data_uncorrectable_flag_line(ucflag), .alloc_enable(alloc)
  );

  bus_node_model i_bus
  (
    .clk(clk), .rst_n(rst_n), .req(req), .bus_phase_zero_pin(t0p),
    .bus_idle_pin(idp), .bus_read_data_pin(rdp), .sys_err_in_pin(erp)
  );

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic stop_test();
    $display("Compared %0d, failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : stop_test

  task automatic chk(string nm, logic [33:0] e, logic [33:0] g);
    n_compared++;
    if (g !== e)
    begin
      n_fail++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // APB transfer; waits for pready, never assumes a latency
  task automatic apb(logic w, logic [11:0] a, logic [31:0] d);
    @(posedge clk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do
      @(posedge clk);
    while (pready !== 1'b1);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(negedge clk);
  endtask : apb

  task automatic rchk(string nm, logic [11:0] a, logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(nm, {2'h0, e}, {2'h0, rd});
  endtask : rchk

  // One-cycle probe; comb answers are judged at the following negedge
  task automatic probe_go(logic cpu, logic rx, logic tp, logic tcp, logic [33:0] a);
    @(posedge clk);
    pr <= '{1'b1, cpu, rx, tp, tcp, a, 20'hA5C3E};
    @(negedge clk);
  endtask : probe_go

  task automatic probe_end();
    @(posedge clk);
    pr <= '0;
    @(negedge clk);
  endtask : probe_end

  task automatic pin(int i);
    @(posedge clk);
    req[i] <= 1'b1;
    @(posedge clk);
    req[i] <= 1'b0;
  endtask : pin

  // Bounded wait for a one-cycle pulse: sync delay is 2, plus 1 register
  task automatic wait_bit(string nm, int i);
    for (int k = 0; k < 8 && wv[i] !== 1'b1; k++)
      @(negedge clk);
    chk(nm, 34'h1, {33'h0, wv[i]});
  endtask : wait_bit

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    rchk("ctrl", tag_parity_pkg::OFF_CTRL, 32'h1);
    chk("mapped err", 34'h0, {33'h0, err});
    chk("alloc", 34'h1, {33'h0, alloc});
    apb(1'b1, 12'h020, 32'hFFFFFFFF);
    chk("unmapped err", 34'h1, {33'h0, err});
    rchk("unmapped", 12'h020, 32'h0);
    @(posedge clk);
    cacheable <= 1'b1;
    pr        <= '{1'b0, 1'b1, 1'b0, 1'b1, 1'b1, A_CPU, 20'h0};
    @(negedge clk);
    chk("probe_req", 34'h1, {33'h0, probe_req});
    chk("no probe", 34'h0, {33'h0, block_data | force_miss});
    probe_end();
  endtask : t_reset

  task automatic t_cpu_err();
    probe_go(1'b1, 1'b1, 1'b1, 1'b0, A_CPU);
    chk("miss", 34'h1, {33'h0, force_miss});
    chk("null", 34'h1, {33'h0, null_tr});
    chk("hard ack", 34'h1, {33'h0, fack});
    chk("block", 34'h1, {33'h0, block_data});
    probe_end();
    chk("mcheck", 34'h1, {33'h0, mchk});
    chk("alloc", 34'h0, {33'h0, alloc});
    rchk("log", tag_parity_pkg::OFF_UE, 32'h1);
    rchk("stat", tag_parity_pkg::OFF_STAT, 32'h1);
    rchk("fa lo", tag_parity_pkg::OFF_FA_LO, A_CPU[31:0]);
    rchk("fa hi", tag_parity_pkg::OFF_FA_HI, {30'h0, A_CPU[33:32]});
    rchk("uea lo", tag_parity_pkg::OFF_UEA_LO, A_CPU[31:0]);
    rchk("tag", tag_parity_pkg::OFF_TAG, 32'h000A5C3E);
    chk("sys err early", 34'h0, {33'h0, sys_err_out});
    pin(0);
    wait_bit("sys err t0", 1);
  endtask : t_cpu_err

  task automatic t_frozen();
    probe_go(1'b0, 1'b0, 1'b0, 1'b1, A_BUS);
    chk("fail", 34'h1, {33'h0, probe_fail});
    probe_end();
    rchk("log", tag_parity_pkg::OFF_UE, 32'h3);
    rchk("uea lo", tag_parity_pkg::OFF_UEA_LO, A_CPU[31:0]);
    apb(1'b1, tag_parity_pkg::OFF_UE, 32'h3);
    rchk("log clr", tag_parity_pkg::OFF_UE, 32'h0);
    chk("alloc", 34'h0, {33'h0, alloc});
    apb(1'b1, tag_parity_pkg::OFF_CTRL, 32'h1);
    chk("alloc", 34'h1, {33'h0, alloc});
  endtask : t_frozen

  task automatic t_bus_err();
    probe_go(1'b0, 1'b1, 1'b1, 1'b0, A_BUS);
    chk("block", 34'h1, {33'h0, block_data});
    chk("fail", 34'h1, {33'h0, probe_fail});
    chk("no miss", 34'h0, {33'h0, force_miss | fack});
    probe_end();
    rchk("log", tag_parity_pkg::OFF_UE, 32'h1);
    rchk("uea lo", tag_parity_pkg::OFF_UEA_LO, A_BUS[31:0]);
    rchk("uea hi", tag_parity_pkg::OFF_UEA_HI, {30'h0, A_BUS[33:32]});
    chk("alloc", 34'h0, {33'h0, alloc});
    pin(2);
    wait_bit("uc flag", 2);
    pin(1);
    wait_bit("sys err idle", 1);
  endtask : t_bus_err

  task automatic t_tc_err();
    apb(1'b1, tag_parity_pkg::OFF_STAT, 32'h3);
    probe_go(1'b1, 1'b0, 1'b0, 1'b1, A_CPU);
    probe_end();
    rchk("stat tc", tag_parity_pkg::OFF_STAT, 32'h2);
  endtask : t_tc_err

  // Data errors: machine check for uncorrectable, interrupt otherwise
  task automatic t_events();
    for (int i = 0; i < 3; i++)
    begin
      @(posedge clk);
      ev[i] <= 1'b1;
      @(posedge clk);
      ev[i] <= 1'b0;
      @(negedge clk);
      chk("event", 34'h1, {33'h0, wv[(i == 0) ? 0 : 3]});
      if (i > 0)
        chk("no mcheck", 34'h0, {33'h0, mchk});
    end
    pin(3);
    wait_bit("irq", 3);
  endtask : t_events

  // ----------------------------------------------------------------
  // Clock, timeout and main sequence
  // ----------------------------------------------------------------
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // Whole run needs well under a thousand cycles
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      n_fail++;
      stop_test();
    end
  end

  initial
  begin
    {rst_n, psel, penable, pwrite, cacheable} = 5'h0;
    {paddr, pwdata, ev, req} = '0;
    pr = '0;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_cpu_err();
    t_frozen();
    t_bus_err();
    t_tc_err();
    t_events();
    stop_test();
  end
endmodule : tb
